/* File: logic/adp_cfg.svh */
// Purpose: Constants for the auxiliary RAM and dual data pointer block
// Assumes: Special function register offsets are byte addresses on the core's SFR port
// Notes:   Included by the package and the design module
`ifndef ADP_CFG_SVH
`define ADP_CFG_SVH
`define ADP_OFS_PTR0_LOW   8'h82
`define ADP_OFS_PTR0_HIGH  8'h83
`define ADP_OFS_PTR1_LOW   8'h84
`define ADP_OFS_PTR1_HIGH  8'h85
`define ADP_OFS_SELECT     8'h86
`define ADP_RST_BYTE       8'h00
`define ADP_RAM_DEPTH      320
`define ADP_RAM_LAST       16'h013F
`define ADP_SEL_BIT        0
`define ADP_CFG_RAM_EN_BIT 4
`define ADP_OOR_READ       8'hFF
`endif

/* File: logic/adp_pkg.sv */
// Purpose: Types for the auxiliary RAM and dual data pointer block
// Assumes: Constants come from adp_cfg.svh
// Notes:   Pointer operation codes as issued by the core
`include "adp_cfg.svh"
package adp_pkg;
  typedef enum logic [2:0] {
    ADP_OP_NONE     = 3'b000,
    ADP_OP_INC      = 3'b001,
    ADP_OP_LOAD     = 3'b010,
    ADP_OP_CODE_RD  = 3'b011,
    ADP_OP_XRAM_RD  = 3'b100,
    ADP_OP_XRAM_WR  = 3'b101,
    ADP_OP_JUMP     = 3'b110
  } adp_ptr_op_t;
endpackage

/* File: logic/adp_aux_ram_active_data_pointer.sv */
// Purpose: Auxiliary data RAM with two switchable 16-bit data pointers
// Assumes: Core presents one request per cycle; RAM and SFR reads answer next cycle
// Notes:   Core adds the accumulator for code reads and jumps using active_data_pointer
//
// Function
// - An auxiliary RAM of 320 bytes at addresses 0 to 319 is read and written by the core.
// - Moves addressed by an 8-bit indirect register reach only the lowest 256 bytes.
// - Moves addressed by the active pointer reach all 320 bytes.
// - RAM reads and writes are blocked while chip configuration bit 4 is zero.
// - RAM traffic is internal, never touches the read strobe pin, never goes off chip.
// - Only select bit 0 exists; 0 picks pointer pair 0 and 1 picks pair 1.
// - Writes to select bits 7 to 1 are ignored and those bits read as zero.
// - Incrementing the select register toggles the select bit.
// - All six pointer instructions act on the currently selected pair.
// - Pointer increment adds one to the full 16-bit value with carry into the high byte.
// - Pointer-addressed RAM moves use the full 16-bit pointer value as address.
// - Reset clears both pointer pairs and the select register to zero.
`timescale 1ns/1ns
`include "adp_cfg.svh"
module adp_aux_ram_active_data_pointer (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic [7:0]           chip_configuration,
  input  wire logic                 sfr_wr,
  input  wire logic                 sfr_rd,
  input  wire logic                 sfr_inc_select,
  input  wire logic [7:0]           sfr_addr,
  input  wire logic [7:0]           sfr_wdata,
  output logic      [7:0]           sfr_rdata,
  input  wire adp_pkg::adp_ptr_op_t ptr_op,
  input  wire logic [15:0]          ptr_load_value,
  input  wire logic                 ri_rd,
  input  wire logic                 ri_wr,
  input  wire logic [7:0]           ri_addr,
  input  wire logic [7:0]           xram_wdata,
  output logic      [7:0]           xram_rdata,
  output logic      [15:0]          active_data_pointer,
  output logic                      read_strobe_port_pin_touch
);
  import adp_pkg::*;

  logic [7:0]  aux_ram [0:`ADP_RAM_DEPTH-1];
  logic [15:0] ptr_reg  [0:1];
  logic [15:0] ptr_next [0:1];
  logic        sel_reg;
  logic        sel_next;
  logic [7:0]  sfr_rdata_reg;
  logic [7:0]  sfr_rdata_next;
  logic [7:0]  xram_rdata_reg;
  logic [7:0]  xram_rdata_next;
  logic        ram_en;
  logic        ram_we;
  logic        ram_re;
  logic [8:0]  ram_addr;
  logic        dp_in_range;

  function automatic logic in_aux_range(input logic [15:0] a);
    in_aux_range = (a <= `ADP_RAM_LAST);
  endfunction

  assign ram_en              = chip_configuration[`ADP_CFG_RAM_EN_BIT];
  assign active_data_pointer = ptr_reg[sel_reg];
  assign dp_in_range         = in_aux_range(active_data_pointer);
  assign read_strobe_port_pin_touch = 1'b0;

  // Register moves zero-extend 8 bits, so they stop at 255
  always_comb begin
    ram_we   = 1'b0;
    ram_re   = 1'b0;
    ram_addr = 9'h000;
    if (ptr_op == ADP_OP_XRAM_WR || ptr_op == ADP_OP_XRAM_RD) begin
      ram_addr = active_data_pointer[8:0];
      ram_we   = ram_en && dp_in_range && (ptr_op == ADP_OP_XRAM_WR);
      ram_re   = ram_en && dp_in_range && (ptr_op == ADP_OP_XRAM_RD);
    end else if (ri_wr || ri_rd) begin
      ram_addr = {1'b0, ri_addr};
      ram_we   = ram_en && ri_wr;
      ram_re   = ram_en && ri_rd;
    end
  end

  // RAM holds no reset; contents are undefined until written
  always_ff @(posedge clock) begin
    if (ram_we) begin
      aux_ram[ram_addr] <= xram_wdata;
    end
  end

  always_comb begin
    xram_rdata_next = xram_rdata_reg;
    if (ram_re) begin
      xram_rdata_next = aux_ram[ram_addr];
    end else if (ptr_op == ADP_OP_XRAM_RD && !dp_in_range) begin
      xram_rdata_next = `ADP_OOR_READ;
    end
  end

  // Pointer pairs and select; SFR write wins over an instruction in the same cycle
  always_comb begin
    ptr_next[0] = ptr_reg[0];
    ptr_next[1] = ptr_reg[1];
    sel_next    = sel_reg;
    if (ptr_op == ADP_OP_INC) begin
      ptr_next[sel_reg] = ptr_reg[sel_reg] + 16'h0001;
    end else if (ptr_op == ADP_OP_LOAD) begin
      ptr_next[sel_reg] = ptr_load_value;
    end
    if (sfr_inc_select) begin
      sel_next = ~sel_reg;
    end else if (sfr_wr) begin
      if (sfr_addr == `ADP_OFS_PTR0_LOW) begin
        ptr_next[0][7:0] = sfr_wdata;
      end else if (sfr_addr == `ADP_OFS_PTR0_HIGH) begin
        ptr_next[0][15:8] = sfr_wdata;
      end else if (sfr_addr == `ADP_OFS_PTR1_LOW) begin
        ptr_next[1][7:0] = sfr_wdata;
      end else if (sfr_addr == `ADP_OFS_PTR1_HIGH) begin
        ptr_next[1][15:8] = sfr_wdata;
      end else if (sfr_addr == `ADP_OFS_SELECT) begin
        sel_next = sfr_wdata[`ADP_SEL_BIT];
      end
    end
  end

  always_comb begin
    sfr_rdata_next = sfr_rdata_reg;
    if (sfr_rd) begin
      if (sfr_addr == `ADP_OFS_PTR0_LOW) begin
        sfr_rdata_next = ptr_reg[0][7:0];
      end else if (sfr_addr == `ADP_OFS_PTR0_HIGH) begin
        sfr_rdata_next = ptr_reg[0][15:8];
      end else if (sfr_addr == `ADP_OFS_PTR1_LOW) begin
        sfr_rdata_next = ptr_reg[1][7:0];
      end else if (sfr_addr == `ADP_OFS_PTR1_HIGH) begin
        sfr_rdata_next = ptr_reg[1][15:8];
      end else if (sfr_addr == `ADP_OFS_SELECT) begin
        sfr_rdata_next = {7'h00, sel_reg};
      end else begin
        sfr_rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ptr_reg[0]     <= {`ADP_RST_BYTE, `ADP_RST_BYTE};
      ptr_reg[1]     <= {`ADP_RST_BYTE, `ADP_RST_BYTE};
      sel_reg        <= 1'b0;
      sfr_rdata_reg  <= `ADP_RST_BYTE;
      xram_rdata_reg <= `ADP_RST_BYTE;
    end else begin
      ptr_reg[0]     <= ptr_next[0];
      ptr_reg[1]     <= ptr_next[1];
      sel_reg        <= sel_next;
      sfr_rdata_reg  <= sfr_rdata_next;
      xram_rdata_reg <= xram_rdata_next;
    end
  end

  assign sfr_rdata  = sfr_rdata_reg;
  assign xram_rdata = xram_rdata_reg;

  AST_INC_ADDS_ONE: assert property (@(posedge clock) disable iff (rst)
    (ptr_op == ADP_OP_INC && !sfr_wr && !sfr_inc_select) |=>
      active_data_pointer == $past(active_data_pointer) + 16'h0001)
    else $error("pointer increment wrong");
  AST_SEL_TOGGLE: assert property (@(posedge clock) disable iff (rst)
    sfr_inc_select |=> sel_reg != $past(sel_reg))
    else $error("select did not toggle");
  AST_SEL_UPPER_ZERO: assert property (@(posedge clock) disable iff (rst)
    (sfr_rd && sfr_addr == `ADP_OFS_SELECT) |=> sfr_rdata[7:1] == 7'h00)
    else $error("select upper bits not zero");
  AST_SEL_PICKS_PAIR: assert property (@(posedge clock) disable iff (rst)
    active_data_pointer == (sel_reg ? ptr_reg[1] : ptr_reg[0]))
    else $error("wrong pair active");
  AST_RESET_CLEAR: assert property (@(posedge clock)
    rst |=> (ptr_reg[0] == 16'h0000 && ptr_reg[1] == 16'h0000 && !sel_reg))
    else $error("reset did not clear pointers");
  AST_DISABLED_NO_WRITE: assert property (@(posedge clock) disable iff (rst)
    !chip_configuration[`ADP_CFG_RAM_EN_BIT] |-> !ram_we && !ram_re)
    else $error("RAM access while disabled");
  AST_OOR_READ: assert property (@(posedge clock) disable iff (rst)
    (ptr_op == ADP_OP_XRAM_RD && active_data_pointer > `ADP_RAM_LAST) |=>
      xram_rdata == `ADP_OOR_READ)
    else $error("out of range read not fixed");
  AST_RI_LOW_256: assert property (@(posedge clock) disable iff (rst)
    (ri_wr && ptr_op != ADP_OP_XRAM_WR && ptr_op != ADP_OP_XRAM_RD) |-> !ram_addr[8])
    else $error("register move beyond 255");
  AST_LOAD_SELECTED: assert property (@(posedge clock) disable iff (rst)
    (ptr_op == ADP_OP_LOAD && !sfr_wr && !sfr_inc_select) |=>
      active_data_pointer == $past(ptr_load_value))
    else $error("load hit wrong pair");
  AST_PIN_UNTOUCHED: assert property (@(posedge clock) disable iff (rst)
    (ram_we || ram_re) |-> !read_strobe_port_pin_touch)
    else $error("pin touched by RAM access");

  // Data-level checks and one out-of-range write enable check, so a wrong data path shows even when the enables look right
  AST_OTHER_PAIR0_KEPT: assert property (@(posedge clock) disable iff (rst)
    ((ptr_op == ADP_OP_INC || ptr_op == ADP_OP_LOAD) && sel_reg && !sfr_wr) |=>
      $stable(ptr_reg[0]))
    else $error("unselected pair 0 changed");
  AST_OTHER_PAIR1_KEPT: assert property (@(posedge clock) disable iff (rst)
    ((ptr_op == ADP_OP_INC || ptr_op == ADP_OP_LOAD) && !sel_reg && !sfr_wr) |=>
      $stable(ptr_reg[1]))
    else $error("unselected pair 1 changed");
  AST_DISABLED_HOLDS_DATA: assert property (@(posedge clock) disable iff (rst)
    (!chip_configuration[`ADP_CFG_RAM_EN_BIT] && ptr_op != ADP_OP_XRAM_RD) |=>
      $stable(xram_rdata))
    else $error("read data changed while disabled");
  AST_SEL_WRITE_BIT0: assert property (@(posedge clock) disable iff (rst)
    (sfr_wr && !sfr_inc_select && sfr_addr == `ADP_OFS_SELECT) |=>
      sel_reg == $past(sfr_wdata[`ADP_SEL_BIT]))
    else $error("select write not taken from bit 0");
  AST_SEL_READ_BIT0: assert property (@(posedge clock) disable iff (rst)
    (sfr_rd && sfr_addr == `ADP_OFS_SELECT) |=>
      sfr_rdata[0] == $past(sel_reg))
    else $error("select read wrong");
  AST_RAM_WRITE_LANDS: assert property (@(posedge clock) disable iff (rst)
    ram_we |=>
      aux_ram[$past(ram_addr)] == $past(xram_wdata))
    else $error("RAM write did not land");
  AST_OOR_WRITE_DROPPED: assert property (@(posedge clock) disable iff (rst)
    (ptr_op == ADP_OP_XRAM_WR && active_data_pointer > `ADP_RAM_LAST) |->
      !ram_we)
    else $error("out of range write reached RAM");
  AST_RESET_READ_ZERO: assert property (@(posedge clock)
    rst |=>
      (sfr_rdata == 8'h00 && xram_rdata == 8'h00))
    else $error("reset did not clear read data");

endmodule

/* File: verification/adp_core_model.sv */
// Purpose: Core model issuing SFR, pointer and move requests
// Assumes: One request per call, held one cycle
// Notes:   Released data shows inverted values
`timescale 1ns/1ns
module adp_core_model (
  input  wire logic         clock,
  output logic              sfr_wr,
  output logic              sfr_rd,
  output logic              sfr_inc_select,
  output logic [7:0]        sfr_addr,
  output logic [7:0]        sfr_wdata,
  output adp_pkg::adp_ptr_op_t ptr_op,
  output logic [15:0]       ptr_load_value,
  output logic              ri_rd,
  output logic              ri_wr,
  output logic [7:0]        ri_addr,
  output logic [7:0]        xram_wdata
);
  import adp_pkg::*;
  initial begin
    {sfr_wr, sfr_rd, sfr_inc_select, ri_rd, ri_wr} = 5'h00;
    {sfr_addr, sfr_wdata, ri_addr, xram_wdata, ptr_load_value} = 48'h0;
    ptr_op = ADP_OP_NONE;
  end
  // k = {wr, rd, inc}; increment is how software swaps pointers
  task automatic sfr(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    {sfr_wr, sfr_rd, sfr_inc_select} <= k;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clock);
    {sfr_wr, sfr_rd, sfr_inc_select} <= 3'h0;
    sfr_addr <= ~a;
    sfr_wdata <= ~d;
  endtask
  // r = {ri_rd, ri_wr}
  task automatic mv(input adp_ptr_op_t o, input logic [1:0] r, input logic [7:0] a,
                    input logic [7:0] d, input logic [15:0] v);
    @(posedge clock);
    ptr_op <= o;
    {ri_rd, ri_wr} <= r;
    ri_addr <= a;
    xram_wdata <= d;
    ptr_load_value <= v;
    @(posedge clock);
    ptr_op <= ADP_OP_NONE;
    {ri_rd, ri_wr} <= 2'h0;
    xram_wdata <= ~d;
  endtask
endmodule

/* File: verification/adp_aux_ram_active_data_pointer_tb_top.sv */
// Purpose: Self-checking bench for the auxiliary RAM and dual pointer block
// Assumes: Core model drives requests; config driven here
// Notes:   Read data sampled 1 ns after the taking edge
`timescale 1ns/1ns
module adp_aux_ram_active_data_pointer_tb_top;
  import adp_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  cfg = 8'h10;
  logic        wr, rd, inc, rr, rw, pin;
  logic [7:0]  sa, sd, sq, ra, xd, xq;
  logic [15:0] lv, adp;
  adp_ptr_op_t op;
  int          fail_count = 0;
  int          tests_run = 0;
  always #2 clock = ~clock;
  adp_core_model i_core (.clock(clock), .sfr_wr(wr), .sfr_rd(rd), .sfr_inc_select(inc),
    .sfr_addr(sa), .sfr_wdata(sd), .ptr_op(op), .ptr_load_value(lv), .ri_rd(rr),
    .ri_wr(rw), .ri_addr(ra), .xram_wdata(xd));
  adp_aux_ram_active_data_pointer i_dut (.clock(clock), .rst(rst), .chip_configuration(cfg),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_inc_select(inc), .sfr_addr(sa), .sfr_wdata(sd),
    .sfr_rdata(sq), .ptr_op(op), .ptr_load_value(lv), .ri_rd(rr), .ri_wr(rw),
    .ri_addr(ra), .xram_wdata(xd), .xram_rdata(xq), .active_data_pointer(adp),
    .read_strobe_port_pin_touch(pin));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rs(input logic [7:0] a, input logic [7:0] e);
    i_core.sfr(3'b010, a, 8'h00);
    #1 chk("sfr_rdata", {8'h00, e}, {8'h00, sq});
  endtask
  task automatic rm(input adp_ptr_op_t o, input logic [1:0] r, input logic [7:0] e);
    i_core.mv(o, r, 8'h10, 8'h00, 16'h0000);
    #1 chk("xram_rdata", {8'h00, e}, {8'h00, xq});
  endtask
  task automatic ld(input logic [15:0] v);
    i_core.mv(ADP_OP_LOAD, 2'b00, 8'h00, 8'h00, v);
  endtask
  task automatic t_select();
    i_core.sfr(3'b100, 8'h84, 8'h34);
    i_core.sfr(3'b100, 8'h85, 8'h12);
    i_core.sfr(3'b100, 8'h86, 8'hFF);
    rs(8'h86, 8'h01);
    chk("active_data_pointer", 16'h1234, adp);
    i_core.sfr(3'b001, 8'h86, 8'h00);
    #1 chk("active_data_pointer", 16'h0000, adp);
    rs(8'h86, 8'h00);
  endtask
  task automatic t_inc();
    ld(16'h00FF);
    i_core.mv(ADP_OP_INC, 2'b00, 8'h00, 8'h00, 16'h0000);
    #1 chk("active_data_pointer", 16'h0100, adp);
    i_core.mv(ADP_OP_CODE_RD, 2'b00, 8'h00, 8'h00, 16'h0000);
    i_core.mv(ADP_OP_JUMP, 2'b00, 8'h00, 8'h00, 16'h0000);
    #1 chk("active_data_pointer", 16'h0100, adp);
    rs(8'h83, 8'h01);
    rs(8'h85, 8'h12);
  endtask
  task automatic t_ram();
    i_core.mv(ADP_OP_NONE, 2'b01, 8'h10, 8'h55, 16'h0000);
    ld(16'h0110);
    i_core.mv(ADP_OP_XRAM_WR, 2'b00, 8'h00, 8'h77, 16'h0000);
    rm(ADP_OP_NONE, 2'b10, 8'h55);
    rm(ADP_OP_XRAM_RD, 2'b10, 8'h77);
    ld(16'h013F);
    i_core.mv(ADP_OP_XRAM_WR, 2'b00, 8'h00, 8'hA5, 16'h0000);
    rm(ADP_OP_XRAM_RD, 2'b00, 8'hA5);
    ld(16'h0140);
    i_core.mv(ADP_OP_XRAM_WR, 2'b00, 8'h00, 8'h11, 16'h0000);
    rm(ADP_OP_XRAM_RD, 2'b00, 8'hFF);
    ld(16'h013F);
    rm(ADP_OP_XRAM_RD, 2'b00, 8'hA5);
  endtask
  task automatic t_dis();
    @(posedge clock);
    cfg <= 8'hEF;
    i_core.mv(ADP_OP_NONE, 2'b01, 8'h10, 8'h99, 16'h0000);
    rm(ADP_OP_NONE, 2'b10, 8'hA5);
    @(posedge clock);
    cfg <= 8'h10;
    rm(ADP_OP_NONE, 2'b10, 8'h55);
    chk("pin_touch", 16'h0000, {15'h0, pin});
  endtask
  task automatic t_alias();
    ld(16'h1110);
    rm(ADP_OP_XRAM_RD, 2'b00, 8'hFF);
    ld(16'h0210);
    i_core.mv(ADP_OP_XRAM_WR, 2'b00, 8'h00, 8'h66, 16'h0000);
    rm(ADP_OP_NONE, 2'b10, 8'h55);
  endtask
  task automatic t_pair1();
    i_core.sfr(3'b001, 8'h86, 8'h00);
    #1 chk("active_data_pointer", 16'h1234, adp);
    ld(16'hFFFF);
    i_core.mv(ADP_OP_INC, 2'b00, 8'h00, 8'h00, 16'h0000);
    #1 chk("active_data_pointer", 16'h0000, adp);
    rs(8'h82, 8'h10);
    rs(8'h83, 8'h02);
    ld(16'h0020);
    i_core.mv(ADP_OP_XRAM_WR, 2'b00, 8'h00, 8'h3C, 16'h0000);
    rm(ADP_OP_XRAM_RD, 2'b00, 8'h3C);
    i_core.sfr(3'b001, 8'h86, 8'h00);
    #1 chk("active_data_pointer", 16'h0210, adp);
    i_core.sfr(3'b101, 8'h86, 8'h00);
    #1 chk("active_data_pointer", 16'h0020, adp);
  endtask
  task automatic t_rst();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1 chk("active_data_pointer", 16'h0000, adp);
    chk("xram_rdata", 16'h0000, {8'h00, xq});
    rs(8'h86, 8'h00);
    rs(8'h84, 8'h00);
  endtask
  task automatic test_done();
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int a = 8'h82; a <= 8'h86; a++) rs(a[7:0], 8'h00);
    chk("active_data_pointer", 16'h0000, adp);
    t_select();
    t_inc();
    t_ram();
    t_dis();
    t_alias();
    t_pair1();
    t_rst();
    test_done();
  end
  initial begin
    #20000;
    fail_count++;
    test_done();
  end
endmodule
